// ---- logic/fws_top.v ----
`timescale 1ns/1ns
`include "fws_map.vh"

module fws_top (
	input wire mclk,
	input wire rstn,
	input wire clk_en,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output wire [20:0] fl_addr,
	output wire [15:0] fl_dq_o,
	output wire fl_dq_oe,
	input wire [15:0] fl_dq_i,
	output wire fl_ce_n,
	output wire fl_oe_n,
	output wire fl_we_n,
	input wire fl_ready_busy_n
);
	localparam [3:0] ST_IDLE = 4'h0;
	localparam [3:0] ST_RD1 = 4'h1;
	localparam [3:0] ST_RD2 = 4'h2;
	localparam [3:0] ST_RECHK = 4'h3;
	localparam [3:0] ST_DATA = 4'h4;
	localparam [3:0] ST_RST = 4'h5;
	localparam [3:0] ST_WPRE = 4'h6;
	localparam [3:0] ST_WCMD = 4'h7;
	localparam [3:0] ST_WPOST = 4'h8;
	localparam [3:0] ST_SREAD = 4'h9;
	localparam [3:0] ST_SWRITE = 4'hA;

	reg [3:0] st_q;
	reg launched_q;
	reg cyc_start_q;
	reg cyc_wr_q;
	reg [15:0] cyc_wdata_q;
	reg [20:0] addr_q;
	reg [15:0] wdata_q;
	reg [15:0] limit_q;
	reg [15:0] cnt_q;
	reg [15:0] rdata_q;
	reg prev_tog_q;
	reg prev_sect_q;
	reg done_q;
	reg pass_q;
	reg fail_q;
	reg pending_q;
	reg win_closed_q;
	reg win_reject_q;
	reg sect_tog_q;
	reg refused_q;
	reg rb_s1_q;
	reg rb_s2_q;
	reg aw_held_q;
	reg w_held_q;
	reg [7:0] awaddr_q;
	reg [31:0] axi_wdata_q;
	reg [3:0] wstrb_q;
	wire cyc_done;
	wire [15:0] cyc_rdata;
	wire wr_commit;
	wire cmd_wr;
	wire [2:0] cmd_op;
	wire busy;
	wire done_set;
	wire refuse_set;
	reg [31:0] rd_mux;
	reg rd_ok;
	wire [31:0] addr_m;
	wire [31:0] wdata_m;
	wire [31:0] limit_m;

	// Byte-lane merge of a register write.
	function [31:0] fws_merge;
		input [31:0] old_v;
		input [31:0] new_v;
		input [3:0] strb;
		integer i;
		begin
			fws_merge = old_v;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i]) begin
					fws_merge[i*8 +: 8] = new_v[i*8 +: 8];
				end
			end
		end
	endfunction

	fws_cycle u_cycle (
		.mclk(mclk),
		.rstn(rstn),
		.clk_en(clk_en),
		.start(cyc_start_q),
		.wr(cyc_wr_q),
		.addr(addr_q),
		.wdata(cyc_wdata_q),
		.done(cyc_done),
		.rdata(cyc_rdata),
		.fl_addr(fl_addr),
		.fl_dq_o(fl_dq_o),
		.fl_dq_oe(fl_dq_oe),
		.fl_dq_i(fl_dq_i),
		.fl_ce_n(fl_ce_n),
		.fl_oe_n(fl_oe_n),
		.fl_we_n(fl_we_n)
	);

	assign busy = (st_q != ST_IDLE);
	assign wr_commit = aw_held_q && w_held_q && !s_axi_bvalid;
	assign cmd_wr = wr_commit && (awaddr_q == `FWS_REG_CMD) && wstrb_q[0];
	assign cmd_op = axi_wdata_q[2:0];
	assign addr_m = fws_merge({11'h000, addr_q}, axi_wdata_q,
		wstrb_q);
	assign wdata_m = fws_merge({16'h0000, wdata_q}, axi_wdata_q,
		wstrb_q);
	assign limit_m = fws_merge({16'h0000, limit_q}, axi_wdata_q,
		wstrb_q);
	assign refuse_set = cmd_wr && busy;
	assign done_set = cyc_done && launched_q && ((st_q == ST_DATA) ||
		(st_q == ST_RST) || (st_q == ST_WPOST) || (st_q == ST_SREAD) ||
		(st_q == ST_SWRITE) || ((st_q == ST_WPRE) &&
		cyc_rdata[`FWS_DQ_WIN_CLOSED]) || ((st_q == ST_RD2) &&
		(cyc_rdata[`FWS_DQ_TOGGLE] != prev_tog_q) &&
		!cyc_rdata[`FWS_DQ_TIME_LIMIT] && (cnt_q == limit_q - 16'h0001)));

	always @(posedge mclk) begin
		if (!rstn) begin
			rb_s1_q <= 1'b1;
			rb_s2_q <= 1'b1;
		end else if (clk_en) begin
			rb_s1_q <= fl_ready_busy_n;
			rb_s2_q <= rb_s1_q;
		end
	end

	always @(posedge mclk) begin
		if (!rstn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `FWS_RESP_OKAY;
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awaddr_q <= 8'h00;
			axi_wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
		end else if (clk_en) begin
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_q <= s_axi_awaddr;
				aw_held_q <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				axi_wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
				w_held_q <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_commit) begin
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_q <= `FWS_REG_STATUS &&
					awaddr_q[1:0] == 2'h0) ? `FWS_RESP_OKAY :
					`FWS_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always @* begin
		rd_mux = 32'h00000000;
		rd_ok = 1'b1;
		case (s_axi_araddr)
		`FWS_REG_CMD: rd_mux = 32'h00000000;
		`FWS_REG_ADDR: rd_mux = {11'h000, addr_q};
		`FWS_REG_WDATA: rd_mux = {16'h0000, wdata_q};
		`FWS_REG_LIMIT: rd_mux = {16'h0000, limit_q};
		`FWS_REG_STATUS: begin
			rd_mux[`FWS_ST_BUSY] = busy;
			rd_mux[`FWS_ST_DONE] = done_q;
			rd_mux[`FWS_ST_PASS] = pass_q;
			rd_mux[`FWS_ST_FAIL] = fail_q;
			rd_mux[`FWS_ST_PENDING] = pending_q;
			rd_mux[`FWS_ST_WIN_CLOSED] = win_closed_q;
			rd_mux[`FWS_ST_WIN_REJECT] = win_reject_q;
			rd_mux[`FWS_ST_SECT_TOGGLE] = sect_tog_q;
			rd_mux[`FWS_ST_READY] = rb_s2_q;
			rd_mux[`FWS_ST_REFUSED] = refused_q;
		end
		`FWS_REG_RDATA: rd_mux = {16'h0000, rdata_q};
		default: rd_ok = 1'b0;
		endcase
	end

	always @(posedge mclk) begin
		if (!rstn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `FWS_RESP_OKAY;
		end else if (clk_en) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= rd_ok ? `FWS_RESP_OKAY : `FWS_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// Register writes and sticky flags; a hardware set beats a clear.
	always @(posedge mclk) begin
		if (!rstn) begin
			addr_q <= 21'h000000;
			wdata_q <= 16'h0000;
			limit_q <= `FWS_LIMIT_RESET;
			done_q <= 1'b0;
			refused_q <= 1'b0;
		end else if (clk_en) begin
			if (wr_commit && awaddr_q == `FWS_REG_ADDR && !busy) begin
				addr_q <= addr_m[20:0];
			end
			if (wr_commit && awaddr_q == `FWS_REG_WDATA) begin
				wdata_q <= wdata_m[15:0];
			end
			if (wr_commit && awaddr_q == `FWS_REG_LIMIT) begin
				limit_q <= limit_m[15:0];
			end
			if (done_set) begin
				done_q <= 1'b1;
			end else if (wr_commit && awaddr_q == `FWS_REG_STATUS &&
				wstrb_q[0] && axi_wdata_q[`FWS_ST_DONE]) begin
				done_q <= 1'b0;
			end
			if (refuse_set) begin
				refused_q <= 1'b1;
			end else if (wr_commit && awaddr_q == `FWS_REG_STATUS &&
				wstrb_q[1] && axi_wdata_q[`FWS_ST_REFUSED]) begin
				refused_q <= 1'b0;
			end
		end
	end

	// Sequencer: one flash cycle per state other than ST_IDLE, ST_RD2 repeating its read up to the limit, each evaluated when it completes.
	always @(posedge mclk) begin
		if (!rstn) begin
			st_q <= ST_IDLE;
			launched_q <= 1'b0;
			cyc_start_q <= 1'b0;
			cyc_wr_q <= 1'b0;
			cyc_wdata_q <= 16'h0000;
			cnt_q <= 16'h0000;
			rdata_q <= 16'h0000;
			prev_tog_q <= 1'b0;
			prev_sect_q <= 1'b0;
			pass_q <= 1'b0;
			fail_q <= 1'b0;
			pending_q <= 1'b0;
			win_closed_q <= 1'b0;
			win_reject_q <= 1'b0;
			sect_tog_q <= 1'b0;
		end else if (clk_en) begin
			cyc_start_q <= 1'b0;
			if (busy && !launched_q) begin
				cyc_start_q <= 1'b1;
				launched_q <= 1'b1;
				cyc_wr_q <= (st_q == ST_RST) || (st_q == ST_WCMD) ||
					(st_q == ST_SWRITE);
				cyc_wdata_q <= (st_q == ST_RST) ? `FWS_RESET_CMD : wdata_q;
			end
			if (cyc_done && launched_q) begin
				launched_q <= 1'b0;
			end
			case (st_q)
			ST_IDLE: begin
				if (cmd_wr) begin
					pass_q <= 1'b0;
					fail_q <= 1'b0;
					pending_q <= 1'b0;
					cnt_q <= 16'h0000;
					case (cmd_op)
					`FWS_OP_POLL: st_q <= ST_RD1;
					`FWS_OP_READ: st_q <= ST_SREAD;
					`FWS_OP_WRITE: st_q <= ST_SWRITE;
					`FWS_OP_ERASE_ADD: begin
						win_reject_q <= 1'b0;
						st_q <= ST_WPRE;
					end
					`FWS_OP_RESET: st_q <= ST_RST;
					default: st_q <= ST_IDLE;
					endcase
				end
			end
			ST_RD1: begin
				if (cyc_done && launched_q) begin
					prev_tog_q <= cyc_rdata[`FWS_DQ_TOGGLE];
					prev_sect_q <= cyc_rdata[`FWS_DQ_SECT_TOGGLE];
					st_q <= ST_RD2;
				end
			end
			ST_RD2: begin
				if (cyc_done && launched_q) begin
					prev_tog_q <= cyc_rdata[`FWS_DQ_TOGGLE];
					prev_sect_q <= cyc_rdata[`FWS_DQ_SECT_TOGGLE];
					sect_tog_q <= cyc_rdata[`FWS_DQ_SECT_TOGGLE] !=
						prev_sect_q;
					if (cyc_rdata[`FWS_DQ_TOGGLE] == prev_tog_q) begin
						st_q <= ST_DATA;
					end else if (cyc_rdata[`FWS_DQ_TIME_LIMIT]) begin
						st_q <= ST_RECHK;
					end else if (cnt_q == limit_q - 16'h0001) begin
						pending_q <= 1'b1;
						st_q <= ST_IDLE;
					end else begin
						cnt_q <= cnt_q + 16'h0001;
					end
				end
			end
			ST_RECHK: begin
				if (cyc_done && launched_q) begin
					if (cyc_rdata[`FWS_DQ_TOGGLE] == prev_tog_q) begin
						st_q <= ST_DATA;
					end else begin
						fail_q <= 1'b1;
						st_q <= ST_RST;
					end
				end
			end
			ST_DATA: begin
				if (cyc_done && launched_q) begin
					rdata_q <= cyc_rdata;
					pass_q <= 1'b1;
					st_q <= ST_IDLE;
				end
			end
			ST_RST: begin
				if (cyc_done && launched_q) begin
					st_q <= ST_IDLE;
				end
			end
			ST_WPRE: begin
				if (cyc_done && launched_q) begin
					win_closed_q <= cyc_rdata[`FWS_DQ_WIN_CLOSED];
					if (cyc_rdata[`FWS_DQ_WIN_CLOSED]) begin
						win_reject_q <= 1'b1;
						st_q <= ST_IDLE;
					end else begin
						st_q <= ST_WCMD;
					end
				end
			end
			ST_WCMD: begin
				if (cyc_done && launched_q) begin
					st_q <= ST_WPOST;
				end
			end
			ST_WPOST: begin
				if (cyc_done && launched_q) begin
					win_closed_q <= cyc_rdata[`FWS_DQ_WIN_CLOSED];
					win_reject_q <= cyc_rdata[`FWS_DQ_WIN_CLOSED];
					pass_q <= !cyc_rdata[`FWS_DQ_WIN_CLOSED];
					st_q <= ST_IDLE;
				end
			end
			ST_SREAD: begin
				if (cyc_done && launched_q) begin
					rdata_q <= cyc_rdata;
					pass_q <= 1'b1;
					st_q <= ST_IDLE;
				end
			end
			ST_SWRITE: begin
				if (cyc_done && launched_q) begin
					pass_q <= 1'b1;
					st_q <= ST_IDLE;
				end
			end
			default: begin
				st_q <= ST_IDLE;
			end
			endcase
		end
	end
endmodule // fws_top

// ---- logic/fws_map.vh ----
`ifndef FWS_MAP_VH
`define FWS_MAP_VH

// Clock and flash timing.
`define FWS_CLK_NS 20
`define FWS_T_RC_NS 70
`define FWS_T_WP_NS 35
`define FWS_T_REC_NS 20
`define FWS_RD_CYC ((`FWS_T_RC_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_WP_CYC ((`FWS_T_WP_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_REC_CYC ((`FWS_T_REC_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_SYNC_CYC 2

// Register offsets.
`define FWS_REG_CMD 8'h00
`define FWS_REG_ADDR 8'h04
`define FWS_REG_WDATA 8'h08
`define FWS_REG_LIMIT 8'h0C
`define FWS_REG_STATUS 8'h10
`define FWS_REG_RDATA 8'h14

// Command codes in the command register.
`define FWS_OP_POLL 3'h1
`define FWS_OP_READ 3'h2
`define FWS_OP_WRITE 3'h3
`define FWS_OP_ERASE_ADD 3'h4
`define FWS_OP_RESET 3'h5

// Status register fields.
`define FWS_ST_BUSY 0
`define FWS_ST_DONE 1
`define FWS_ST_PASS 2
`define FWS_ST_FAIL 3
`define FWS_ST_PENDING 4
`define FWS_ST_WIN_CLOSED 5
`define FWS_ST_WIN_REJECT 6
`define FWS_ST_SECT_TOGGLE 7
`define FWS_ST_READY 8
`define FWS_ST_REFUSED 9

// Flash status bit positions on the data bus.
`define FWS_DQ_POLL 7
`define FWS_DQ_TOGGLE 6
`define FWS_DQ_TIME_LIMIT 5
`define FWS_DQ_WIN_CLOSED 3
`define FWS_DQ_SECT_TOGGLE 2

// Reset values, command data and response codes.
`define FWS_LIMIT_RESET 16'h0100
`define FWS_RESET_CMD 16'h00F0
`define FWS_RESP_OKAY 2'h0
`define FWS_RESP_SLVERR 2'h2

`endif

// ---- logic/fws_cycle.v ----
`timescale 1ns/1ns
`include "fws_map.vh"

module fws_cycle (
	input wire mclk,
	input wire rstn,
	input wire clk_en,
	input wire start,
	input wire wr,
	input wire [20:0] addr,
	input wire [15:0] wdata,
	output reg done,
	output reg [15:0] rdata,
	output reg [20:0] fl_addr,
	output reg [15:0] fl_dq_o,
	output reg fl_dq_oe,
	input wire [15:0] fl_dq_i,
	output reg fl_ce_n,
	output reg fl_oe_n,
	output reg fl_we_n
);
	localparam [1:0] C_IDLE = 2'h0;
	localparam [1:0] C_RD = 2'h1;
	localparam [1:0] C_WR = 2'h2;
	localparam [1:0] C_REC = 2'h3;
	localparam integer RD_WAIT_N = `FWS_RD_CYC + `FWS_SYNC_CYC - 1;
	localparam integer WP_WAIT_N = `FWS_WP_CYC - 1;
	localparam integer REC_WAIT_N = `FWS_REC_CYC - 1;
	localparam [3:0] RD_WAIT = RD_WAIT_N[3:0];
	localparam [3:0] WP_WAIT = WP_WAIT_N[3:0];
	localparam [3:0] REC_WAIT = REC_WAIT_N[3:0];

	reg [1:0] st_q;
	reg [3:0] cnt_q;
	reg [15:0] dq_s1_q;
	reg [15:0] dq_s2_q;

	// Data pins are asynchronous to mclk and pass two flip-flops.
	always @(posedge mclk) begin
		if (!rstn) begin
			dq_s1_q <= 16'h0000;
			dq_s2_q <= 16'h0000;
		end else if (clk_en) begin
			dq_s1_q <= fl_dq_i;
			dq_s2_q <= dq_s1_q;
		end
	end

	always @(posedge mclk) begin
		if (!rstn) begin
			st_q <= C_IDLE;
			cnt_q <= 4'h0;
			done <= 1'b0;
			rdata <= 16'h0000;
			fl_addr <= 21'h000000;
			fl_dq_o <= 16'h0000;
			fl_dq_oe <= 1'b0;
			fl_ce_n <= 1'b1;
			fl_oe_n <= 1'b1;
			fl_we_n <= 1'b1;
		end else if (clk_en) begin
			done <= 1'b0;
			case (st_q)
			C_IDLE: begin
				if (start) begin
					fl_addr <= addr;
					fl_ce_n <= 1'b0;
					if (wr) begin
						fl_dq_o <= wdata;
						fl_dq_oe <= 1'b1;
						fl_we_n <= 1'b0;
						cnt_q <= WP_WAIT;
						st_q <= C_WR;
					end else begin
						fl_oe_n <= 1'b0;
						cnt_q <= RD_WAIT;
						st_q <= C_RD;
					end
				end
			end
			C_RD: begin
				if (cnt_q == 4'h0) begin
					rdata <= dq_s2_q;
					fl_ce_n <= 1'b1;
					fl_oe_n <= 1'b1;
					cnt_q <= REC_WAIT;
					st_q <= C_REC;
				end else begin
					cnt_q <= cnt_q - 4'h1;
				end
			end
			C_WR: begin
				if (cnt_q == 4'h0) begin
					fl_ce_n <= 1'b1;
					fl_we_n <= 1'b1;
					cnt_q <= REC_WAIT;
					st_q <= C_REC;
				end else begin
					cnt_q <= cnt_q - 4'h1;
				end
			end
			C_REC: begin
				if (cnt_q == 4'h0) begin
					fl_dq_oe <= 1'b0;
					done <= 1'b1;
					st_q <= C_IDLE;
				end else begin
					cnt_q <= cnt_q - 4'h1;
				end
			end
			default: begin
				st_q <= C_IDLE;
			end
			endcase
		end
	end
endmodule // fws_cycle

// ---- tb/fws_checker.sv ----
`timescale 1ns/1ns
module fws_checker (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic [20:0] fl_addr,
	input wire logic fl_dq_oe,
	input wire logic fl_ce_n,
	input wire logic fl_oe_n,
	input wire logic fl_we_n
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rstn);
	read_pulse_a: assert property ($fell(fl_oe_n) |->
		(!fl_oe_n && !fl_ce_n)[*5] ##[1:2] fl_oe_n)
		else $error("read strobe length wrong");
	write_pulse_a: assert property ($fell(fl_we_n) |->
		(fl_dq_oe && !fl_ce_n)[*2] ##1 (fl_we_n && fl_dq_oe))
		else $error("write strobe length wrong");
	bus_turn_a: assert property (!fl_oe_n |-> !fl_dq_oe && fl_we_n)
		else $error("data bus driven during read");
	addr_hold_a: assert property (!fl_oe_n && $past(!fl_oe_n) |->
		$stable(fl_addr))
		else $error("address moved during read");
	b_latency_a: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	r_latency_a: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid)
		else $error("read response late");
	rd_slverr_a: assert property (s_axi_arvalid && s_axi_arready &&
		s_axi_araddr > 8'h14 |=> s_axi_rresp == 2'h2)
		else $error("unmapped read not refused");
	one_write_a: assert property (s_axi_bvalid |->
		!s_axi_awready && !s_axi_wready)
		else $error("write accepted during response");
	cover property ($fell(fl_we_n));
	cover property ($fell(fl_oe_n));
	cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // fws_checker
bind fws_top fws_checker fws_checker_i (.mclk(mclk), .rstn(rstn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.fl_addr(fl_addr), .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n),
	.fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n));

// ---- tb/fws_flash_model.sv ----
`timescale 1ns/1ns
module fws_flash_model (
	input wire logic [20:0] fl_addr,
	input wire logic [15:0] fl_dq_o,
	output logic [15:0] fl_dq_i,
	input wire logic fl_ce_n,
	input wire logic fl_oe_n,
	input wire logic fl_we_n,
	output wire fl_ready_busy_n
);
	logic [15:0] arr = 16'h1234;
	logic [15:0] wd = 16'h0000;
	logic [20:0] ra = 21'h000000;
	logic tog = 1'b0;
	logic d5 = 1'b0;
	logic win = 1'b0;
	logic fail = 1'b0;
	logic shut = 1'b0;
	int busy = 0;
	int n_wr = 0;
	int n_rst = 0;
	assign fl_ready_busy_n = (busy > 0 || fail) ? 1'b0 : 1'bz;
	initial fl_dq_i = 16'h0000;
	always @(negedge fl_oe_n) begin
		ra = fl_addr;
		if (busy > 0 || fail) begin
			tog = ~tog;
			if (!fail)
				busy = busy - 1;
			fl_dq_i = {8'h00, ~wd[7], tog, d5 | fail, 1'b0, win, tog,
				2'b00};
		end else
			fl_dq_i = arr;
	end
	always @(posedge fl_oe_n)
		fl_dq_i = ~fl_dq_i;
	always @(negedge fl_we_n) begin
		if (fl_dq_o == 16'h00F0) begin
			fail = 1'b0;
			busy = 0;
			n_rst++;
		end else if (shut) begin
			win = 1'b1;
		end else if (!win) begin
			n_wr++;
			wd = fl_dq_o;
			if (|(fl_dq_o & ~arr))
				fail = 1'b1;
		end
	end
endmodule // fws_flash_model

// ---- tb/fws_top_tb_top.sv ----
`timescale 1ns/1ns
module fws_top_tb_top;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] awa = 8'h00;
	logic [7:0] ara = 8'h00;
	logic [31:0] wd = 32'h0;
	logic awv = 1'b0;
	logic wv = 1'b0;
	logic br = 1'b0;
	logic arv = 1'b0;
	logic rr = 1'b0;
	logic [31:0] st;
	wire awr, wr, bv, arr, rv, oe, ce_n, oe_n, we_n, rb;
	wire [1:0] bre, rre;
	wire [31:0] rd;
	wire [20:0] fa;
	wire [15:0] dqo, dqi;
	int n_errors = 0;
	int n_checks = 0;
	pullup (rb);
	always #10 mclk = ~mclk;
	fws_top fws_top_i (.mclk(mclk), .rstn(rstn), .clk_en(1'b1),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
		.s_axi_wready(wr), .s_axi_bresp(bre), .s_axi_bvalid(bv),
		.s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rre),
		.s_axi_rvalid(rv), .s_axi_rready(rr), .fl_addr(fa),
		.fl_dq_o(dqo), .fl_dq_oe(oe), .fl_dq_i(dqi), .fl_ce_n(ce_n),
		.fl_oe_n(oe_n), .fl_we_n(we_n), .fl_ready_busy_n(rb));
	fws_flash_model fws_flash_model_i (.fl_addr(fa), .fl_dq_o(dqo),
		.fl_dq_i(dqi), .fl_ce_n(ce_n), .fl_oe_n(oe_n), .fl_we_n(we_n),
		.fl_ready_busy_n(rb));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected at %0t ns: got %h want %h", $time, g, e);
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic ta, tw;
		ta = 1'b0;
		tw = 1'b0;
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		while (!(ta && tw)) begin
			@(posedge mclk);
			if (!ta && awr) begin
				ta = 1'b1;
				awv <= 1'b0;
			end
			if (!tw && wr) begin
				tw = 1'b1;
				wv <= 1'b0;
			end
		end
		br <= 1'b1;
		@(posedge mclk);
		while (!bv) @(posedge mclk);
		br <= 1'b0;
		chk({30'h0, bre}, {30'h0, er});
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] d,
		input logic [1:0] er);
		ara <= a;
		arv <= 1'b1;
		@(posedge mclk);
		while (!arr) @(posedge mclk);
		arv <= 1'b0;
		rr <= 1'b1;
		@(posedge mclk);
		while (!rv) @(posedge mclk);
		rr <= 1'b0;
		d = rd;
		chk({30'h0, rre}, {30'h0, er});
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		logic [31:0] d;
		axr(a, d, 2'h0);
		chk(d & m, e);
	endtask
	task automatic run(input logic [2:0] op);
		axw(8'h10, 32'h202, 2'h0);
		axw(8'h00, {29'h0, op}, 2'h0);
		for (int i = 0; i < 400; i++) begin
			axr(8'h10, st, 2'h0);
			if (st[1] === 1'b1)
				break;
		end
		chk({31'h0, st[1]}, 32'h1);
	endtask
	task automatic arm(input int b, input logic f5);
		fws_flash_model_i.busy = b;
		fws_flash_model_i.tog = 1'b0;
		fws_flash_model_i.d5 = f5;
	endtask
	task automatic s_regs();
		rdc(8'h0C, 32'hFFFF, 32'h0100);
		axr(8'h18, st, 2'h2);
		chk(st, 32'h0);
		axw(8'h14, 32'h1, 2'h2);
		axw(8'h0C, 32'h4, 2'h0);
		rdc(8'h0C, 32'hFFFF, 32'h4);
	endtask
	task automatic s_poll(input int b, input logic f5);
		arm(b, f5);
		axw(8'h04, 32'h5, 2'h0);
		run(3'h1);
		rdc(8'h10, 32'h1C, 32'h04);
		rdc(8'h10, 32'h80, (b > 0) ? 32'h80 : 32'h0);
		rdc(8'h14, 32'hFFFF, 32'h1234);
		chk({11'h0, fws_flash_model_i.ra}, 32'h5);
		chk(fws_flash_model_i.n_rst, 0);
		arm(0, 1'b0);
	endtask
	task automatic s_pend();
		arm(40, 1'b0);
		axw(8'h00, 32'h1, 2'h0);
		axw(8'h00, 32'h1, 2'h0);
		rdc(8'h10, 32'h1, 32'h1);
		run(3'h0);
		rdc(8'h10, 32'h21D, 32'h210);
		arm(0, 1'b0);
		run(3'h1);
		rdc(8'h10, 32'h1C, 32'h04);
	endtask
	task automatic s_fail();
		axw(8'h08, 32'h0234, 2'h0);
		run(3'h3);
		chk(fws_flash_model_i.n_wr, 1);
		axw(8'h08, 32'h0235, 2'h0);
		run(3'h3);
		rdc(8'h10, 32'h100, 32'h0);
		arm(0, 1'b0);
		run(3'h1);
		rdc(8'h10, 32'h1C, 32'h08);
		chk(fws_flash_model_i.n_rst, 1);
		repeat (8) @(posedge mclk);
		rdc(8'h10, 32'h100, 32'h100);
	endtask
	task automatic s_erase();
		axw(8'h08, 32'h0030, 2'h0);
		arm(1000, 1'b0);
		run(3'h4);
		chk(fws_flash_model_i.n_wr, 3);
		rdc(8'h10, 32'h60, 32'h0);
		fws_flash_model_i.shut = 1'b1;
		run(3'h4);
		chk(fws_flash_model_i.n_wr, 3);
		rdc(8'h10, 32'h64, 32'h60);
		fws_flash_model_i.win = 1'b1;
		run(3'h4);
		chk(fws_flash_model_i.n_wr, 3);
		rdc(8'h10, 32'h60, 32'h60);
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge mclk);
		n_errors++;
		close_out();
	end
	initial begin
		repeat (16) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		s_regs();
		s_poll(0, 1'b0);
		s_poll(2, 1'b0);
		s_poll(2, 1'b1);
		s_pend();
		s_fail();
		s_erase();
		close_out();
	end
endmodule // fws_top_tb_top
